// ===== design/dtc_top.sv
// Functional notes
// - two-bit field picks one of four modes
// - mode 00: 8-bit count behind divide-by-32
// - mode 11: timer 0 splits, timer 1 stops
// - timer function counts every machine cycle
// - counter function counts count-pin falling edges
// - edge detect takes two machine cycles
// - gate pins may gate counting for pulse width
`timescale 1ns/10ps
module dtc_top (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // external pins
  input  wire logic        count_input_zero_in,
  input  wire logic        count_input_one_in,
  input  wire logic        gate_input_zero_in,
  input  wire logic        gate_input_one_in,
  // overflow flags
  output logic [1:0]       ovf_flag_out
);

  typedef struct packed {
    logic [2:0]  mdiv;
    logic        mcyc;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [7:0]  mode;
    logic [1:0]  run;
    logic [1:0]  ovf;
    logic [31:0] rdata;
    logic        ready;
  } dtc_top_state_type;

  dtc_top_state_type                st_ff;
  dtc_top_state_type                nxt_st;
  logic [dtc_pkg::PIN_NUM-1:0]      pin_raw;
  logic [dtc_pkg::PIN_NUM-1:0]      pin_fall;
  logic [dtc_pkg::PIN_NUM-1:0]      pin_lvl;
  logic                             addr_take;

  dtc_unit_if u0 ();
  dtc_unit_if u1 ();

  assign pin_raw[dtc_pkg::PIN_COUNT0] = count_input_zero_in;
  assign pin_raw[dtc_pkg::PIN_COUNT1] = count_input_one_in;
  assign pin_raw[dtc_pkg::PIN_GATE0]  = gate_input_zero_in;
  assign pin_raw[dtc_pkg::PIN_GATE1]  = gate_input_one_in;

  dtc_pin_sampler u_smp (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .mcyc_en_in (st_ff.mcyc),
    .pin_in     (pin_raw),
    .fall_out   (pin_fall),
    .lvl_out    (pin_lvl)
  );

  // timer 0: the only unit that can split
  assign u0.mcyc_en  = st_ff.mcyc;
  assign u0.run      = st_ff.run[dtc_pkg::RUN0_BIT];
  assign u0.run_hi   = st_ff.run[dtc_pkg::RUN1_BIT];
  assign u0.ct_sel   = st_ff.mode[dtc_pkg::MODE_CT_BIT];
  assign u0.gate_en  = st_ff.mode[dtc_pkg::MODE_GATE_BIT];
  assign u0.split_en = 1'b1;
  assign u0.mode     = st_ff.mode[dtc_pkg::MODE_SEL_HI:dtc_pkg::MODE_SEL_LO];
  assign u0.cnt_edge = pin_fall[dtc_pkg::PIN_COUNT0];
  assign u0.gate_lvl = pin_lvl[dtc_pkg::PIN_GATE0];
  assign u0.wr_en    = st_ff.wr_pend && (st_ff.wr_addr == dtc_pkg::ADDR_COUNT0);
  assign u0.wr_data  = hwdata_in[15:0];

  // timer 1: its split mode halts it
  assign u1.mcyc_en  = st_ff.mcyc;
  assign u1.run      = st_ff.run[dtc_pkg::RUN1_BIT];
  assign u1.run_hi   = 1'b0;
  assign u1.ct_sel   = st_ff.mode[dtc_pkg::MODE_TMR1_BASE + dtc_pkg::MODE_CT_BIT];
  assign u1.gate_en  = st_ff.mode[dtc_pkg::MODE_TMR1_BASE + dtc_pkg::MODE_GATE_BIT];
  assign u1.split_en = 1'b0;
  assign u1.mode     = st_ff.mode[dtc_pkg::MODE_TMR1_BASE + dtc_pkg::MODE_SEL_HI:
                                  dtc_pkg::MODE_TMR1_BASE + dtc_pkg::MODE_SEL_LO];
  assign u1.cnt_edge = pin_fall[dtc_pkg::PIN_COUNT1];
  assign u1.gate_lvl = pin_lvl[dtc_pkg::PIN_GATE1];
  assign u1.wr_en    = st_ff.wr_pend && (st_ff.wr_addr == dtc_pkg::ADDR_COUNT1);
  assign u1.wr_data  = hwdata_in[15:0];

  dtc_unit u_tmr0 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ifc        (u0.unit)
  );

  dtc_unit u_tmr1 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .ifc        (u1.unit)
  );

  assign addr_take = hsel_in && hready_in && (htrans_in == dtc_pkg::HTRANS_NONSEQ);

  always_comb begin
    nxt_st = st_ff;
    // machine cycle strobe, one clock in six
    if (st_ff.mdiv == dtc_pkg::MCYC_LAST) begin
      nxt_st.mdiv = dtc_pkg::MCYC_DIV_RST;
      nxt_st.mcyc = 1'b1;
    end else begin
      nxt_st.mdiv = st_ff.mdiv + 3'h1;
      nxt_st.mcyc = 1'b0;
    end

    // data phase of a pending write
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        dtc_pkg::ADDR_MODE:   nxt_st.mode = hwdata_in[7:0];
        dtc_pkg::ADDR_CTRL:   nxt_st.run  = hwdata_in[1:0];
        dtc_pkg::ADDR_STATUS: nxt_st.ovf  = st_ff.ovf & ~hwdata_in[1:0];
        default:              nxt_st.ovf  = st_ff.ovf;
      endcase
    end
    // overflow sets after the clear so a same-cycle event is kept
    if (u0.ovf_lo) begin
      nxt_st.ovf[dtc_pkg::OVF0_BIT] = 1'b1;
    end
    if (u0.ovf_hi || u1.ovf_lo) begin
      nxt_st.ovf[dtc_pkg::OVF1_BIT] = 1'b1;
    end

    // address phase: reads are snapshotted here so the data phase needs no wait
    nxt_st.wr_pend = addr_take && hwrite_in;
    nxt_st.wr_addr = haddr_in;
    if (addr_take && !hwrite_in) begin
      case (haddr_in)
        dtc_pkg::ADDR_MODE:   nxt_st.rdata = {24'h000000, st_ff.mode};
        dtc_pkg::ADDR_CTRL:   nxt_st.rdata = {30'h00000000, st_ff.run};
        dtc_pkg::ADDR_STATUS: nxt_st.rdata = {30'h00000000, st_ff.ovf};
        dtc_pkg::ADDR_COUNT0: nxt_st.rdata = {16'h0000, u0.count};
        dtc_pkg::ADDR_COUNT1: nxt_st.rdata = {16'h0000, u1.count};
        default:              nxt_st.rdata = 32'h00000000;
      endcase
    end
    nxt_st.ready = 1'b1;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '{mdiv: dtc_pkg::MCYC_DIV_RST, mcyc: 1'b0, wr_pend: 1'b0,
                 wr_addr: 32'h00000000, mode: dtc_pkg::MODE_RST,
                 run: dtc_pkg::RUN_RST, ovf: dtc_pkg::OVF_RST,
                 rdata: 32'h00000000, ready: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata_out    = st_ff.rdata;
  assign hreadyout_out = st_ff.ready;
  assign hresp_out     = dtc_pkg::HRESP_OKAY;
  assign ovf_flag_out  = st_ff.ovf;

endmodule

// ===== design/dtc_pkg.sv
package dtc_pkg;

  // oscillator is the system clock; one machine cycle is six of its periods
  localparam int          OSC_PERIOD_NS   = 40;
  localparam int          MCYC_NS         = 240;
  localparam int          MCYC_CLKS       = MCYC_NS / OSC_PERIOD_NS;
  localparam logic [2:0]  MCYC_LAST       = 3'(MCYC_CLKS - 1);
  localparam logic [2:0]  MCYC_DIV_RST    = 3'h0;

  // mode 00 prescaler divides count events by 32
  localparam int          PRESCALE_DIV    = 32;
  localparam logic [4:0]  PRESCALE_LAST   = 5'(PRESCALE_DIV - 1);
  localparam logic [4:0]  PRESCALE_RST    = 5'h00;

  // two-bit mode field codes
  localparam logic [1:0]  MODE_PRESCALE   = 2'h0;
  localparam logic [1:0]  MODE_WIDE       = 2'h1;
  localparam logic [1:0]  MODE_RELOAD     = 2'h2;
  localparam logic [1:0]  MODE_SPLIT      = 2'h3;

  // register byte addresses
  localparam logic [31:0] ADDR_MODE       = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL       = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS     = 32'h0000_0008;
  localparam logic [31:0] ADDR_COUNT0     = 32'h0000_000c;
  localparam logic [31:0] ADDR_COUNT1     = 32'h0000_0010;

  // timer_mode_register fields, per timer base 0 (timer 0) or 4 (timer 1)
  localparam int          MODE_TMR1_BASE  = 4;
  localparam int          MODE_SEL_LO     = 0;
  localparam int          MODE_SEL_HI     = 1;
  localparam int          MODE_CT_BIT     = 2;
  localparam int          MODE_GATE_BIT   = 3;
  localparam logic [7:0]  MODE_RST        = 8'h00;

  // control and status fields
  localparam int          RUN0_BIT        = 0;
  localparam int          RUN1_BIT        = 1;
  localparam logic [1:0]  RUN_RST         = 2'h0;
  localparam int          OVF0_BIT        = 0;
  localparam int          OVF1_BIT        = 1;
  localparam logic [1:0]  OVF_RST         = 2'h0;
  localparam logic [15:0] COUNT_RST       = 16'h0000;

  // pin order in the sampler
  localparam int          PIN_COUNT0      = 0;
  localparam int          PIN_COUNT1      = 1;
  localparam int          PIN_GATE0       = 2;
  localparam int          PIN_GATE1       = 3;
  localparam int          PIN_NUM         = 4;

  // ahb-lite
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

endpackage

// ===== design/dtc_unit_if.sv
`timescale 1ns/10ps
interface dtc_unit_if;
  logic        mcyc_en;
  logic        run;
  logic        run_hi;
  logic        ct_sel;
  logic        gate_en;
  logic        split_en;
  logic [1:0]  mode;
  logic        cnt_edge;
  logic        gate_lvl;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] count;
  logic        ovf_lo;
  logic        ovf_hi;

  modport ctl (
    output mcyc_en, run, run_hi, ct_sel, gate_en, split_en, mode,
    output cnt_edge, gate_lvl, wr_en, wr_data,
    input  count, ovf_lo, ovf_hi
  );
  modport unit (
    input  mcyc_en, run, run_hi, ct_sel, gate_en, split_en, mode,
    input  cnt_edge, gate_lvl, wr_en, wr_data,
    output count, ovf_lo, ovf_hi
  );
endinterface

// ===== design/dtc_pin_sampler.sv
`timescale 1ns/10ps
module dtc_pin_sampler (
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  // machine cycle strobe
  input  wire logic                          mcyc_en_in,
  // raw pins
  input  wire logic [dtc_pkg::PIN_NUM-1:0]   pin_in,
  // sampled results
  output logic      [dtc_pkg::PIN_NUM-1:0]   fall_out,
  output logic      [dtc_pkg::PIN_NUM-1:0]   lvl_out
);

  typedef struct packed {
    logic [dtc_pkg::PIN_NUM-1:0] sync1;
    logic [dtc_pkg::PIN_NUM-1:0] sync2;
    logic [dtc_pkg::PIN_NUM-1:0] smp;
    logic [dtc_pkg::PIN_NUM-1:0] fall;
  } dtc_smp_state_type;

  dtc_smp_state_type st_ff;
  dtc_smp_state_type nxt_st;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.fall  = '0;
    if (mcyc_en_in) begin
      // one sample per machine cycle; a fall needs two samples
      nxt_st.smp  = st_ff.sync2;
      nxt_st.fall = st_ff.smp & ~st_ff.sync2;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      // idle pins read high so release does not fake a fall
      st_ff <= '{sync1: '1, sync2: '1, smp: '1, fall: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_out = st_ff.fall;
  assign lvl_out  = st_ff.smp;

endmodule

// ===== design/dtc_unit.sv
`timescale 1ns/10ps
module dtc_unit (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // control and count
  dtc_unit_if.unit  ifc
);

  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf_lo;
    logic       ovf_hi;
  } dtc_unit_state_type;

  dtc_unit_state_type st_ff;
  dtc_unit_state_type nxt_st;
  logic               tick_lo;
  logic               tick_hi;
  logic [16:0]        wide_sum;

  // gate pin holds counting off while enabled and low
  assign tick_lo = ifc.run && (!ifc.gate_en || ifc.gate_lvl) &&
                   (ifc.ct_sel ? ifc.cnt_edge : ifc.mcyc_en);
  assign tick_hi = ifc.run_hi && ifc.mcyc_en;
  assign wide_sum = {1'b0, st_ff.hi, st_ff.lo} + 17'h00001;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.ovf_lo = 1'b0;
    nxt_st.ovf_hi = 1'b0;
    case (ifc.mode)
      dtc_pkg::MODE_PRESCALE: begin
        if (tick_lo) begin
          nxt_st.pre = st_ff.pre + 5'h01;
          if (st_ff.pre == dtc_pkg::PRESCALE_LAST) begin
            nxt_st.lo     = st_ff.lo + 8'h01;
            nxt_st.ovf_lo = (st_ff.lo == 8'hff);
          end
        end
      end
      dtc_pkg::MODE_WIDE: begin
        if (tick_lo) begin
          {nxt_st.hi, nxt_st.lo} = wide_sum[15:0];
          nxt_st.ovf_lo          = wide_sum[16];
        end
      end
      dtc_pkg::MODE_RELOAD: begin
        if (tick_lo) begin
          // high byte is the reload value and never counts
          if (st_ff.lo == 8'hff) begin
            nxt_st.lo     = st_ff.hi;
            nxt_st.ovf_lo = 1'b1;
          end else begin
            nxt_st.lo = st_ff.lo + 8'h01;
          end
        end
      end
      dtc_pkg::MODE_SPLIT: begin
        // a unit without split support just holds its count
        if (ifc.split_en) begin
          if (tick_lo) begin
            nxt_st.lo     = st_ff.lo + 8'h01;
            nxt_st.ovf_lo = (st_ff.lo == 8'hff);
          end
          if (tick_hi) begin
            nxt_st.hi     = st_ff.hi + 8'h01;
            nxt_st.ovf_hi = (st_ff.hi == 8'hff);
          end
        end
      end
      default: begin
        nxt_st = st_ff;
      end
    endcase
    // software load beats a same-cycle increment
    if (ifc.wr_en) begin
      nxt_st.lo  = ifc.wr_data[7:0];
      nxt_st.hi  = ifc.wr_data[15:8];
      nxt_st.pre = dtc_pkg::PRESCALE_RST;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '{pre: dtc_pkg::PRESCALE_RST, lo: 8'h00, hi: 8'h00,
                 ovf_lo: 1'b0, ovf_hi: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ifc.count  = {st_ff.hi, st_ff.lo};
  assign ifc.ovf_lo = st_ff.ovf_lo;
  assign ifc.ovf_hi = st_ff.ovf_hi;

endmodule

// ===== tb/dtc_top_sva.sv
`timescale 1ns/10ps
module dtc_top_sva (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // bus
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // flags
  input wire logic [1:0]  ovf_flag_out
);
  logic        ph_v_ff;
  logic        ph_wr_ff;
  logic [31:0] ph_a_ff;
  logic [7:0]  mode_ff;
  logic [1:0]  run_ff;
  logic        ran_ff;
  logic [3:0]  stop_ff;
  wire take    = hsel_in && hready_in && htrans_in == dtc_pkg::HTRANS_NONSEQ;
  wire wr_dp   = ph_v_ff && ph_wr_ff;
  wire rd_dp   = ph_v_ff && !ph_wr_ff;
  // timer 1 halted by its own split code while timer 0 is not split
  wire u1_halt = mode_ff[5:4] == 2'h3 && mode_ff[1:0] != 2'h3;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {ph_v_ff, ph_wr_ff, ph_a_ff, mode_ff, run_ff, ran_ff, stop_ff} <= '0;
    end else begin
      ph_v_ff  <= take;
      ph_wr_ff <= hwrite_in;
      ph_a_ff  <= haddr_in;
      if (wr_dp && ph_a_ff == dtc_pkg::ADDR_MODE) mode_ff <= hwdata_in[7:0];
      if (wr_dp && ph_a_ff == dtc_pkg::ADDR_CTRL) run_ff <= hwdata_in[1:0];
      ran_ff  <= ran_ff | run_ff[0];
      stop_ff <= !u1_halt ? 4'h0 : (stop_ff == 4'hf ? stop_ff : stop_ff + 4'h1);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_ready_always: assert property (hreadyout_out) else $error("wait state seen");
  a_resp_okay: assert property (hresp_out == dtc_pkg::HRESP_OKAY) else $error("bad resp");
  a_mode_read: assert property (rd_dp && ph_a_ff == dtc_pkg::ADDR_MODE
    |-> hrdata_out == {24'h0, $past(mode_ff)}) else $error("mode readback");
  a_ctrl_read: assert property (rd_dp && ph_a_ff == dtc_pkg::ADDR_CTRL
    |-> hrdata_out == {30'h0, $past(run_ff)}) else $error("ctrl readback");
  a_unmapped_zero: assert property (rd_dp && ph_a_ff > dtc_pkg::ADDR_COUNT1
    |-> hrdata_out == 32'h0) else $error("unmapped read not zero");
  a_ovf_needs_run: assert property ($rose(ovf_flag_out[0]) |-> ran_ff)
    else $error("overflow without run");
  a_t1_stops: assert property ($rose(ovf_flag_out[1]) |-> stop_ff < 4'h8)
    else $error("stopped timer overflowed");
  a_ovf_clear: assert property (wr_dp && ph_a_ff == dtc_pkg::ADDR_STATUS && hwdata_in[0]
    && run_ff == 2'h0 && $past(run_ff, 4) == 2'h0 |-> ##[1:2] !ovf_flag_out[0])
    else $error("overflow flag not cleared");

  c_ovf0: cover property ($rose(ovf_flag_out[0]));
  c_ovf1: cover property ($rose(ovf_flag_out[1]));
  c_split: cover property (rd_dp && mode_ff == 8'h33);
endmodule

bind dtc_top dtc_top_sva u_sva (.sys_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .ovf_flag_out);

// ===== tb/dtc_pin_model.sv
`timescale 1ns/10ps
module dtc_pin_model (
  // clock
  input  wire logic sys_clk_in,
  // pins, idle high as with pull-ups
  output logic      cnt0_out,
  output logic      cnt1_out,
  output logic      gate0_out,
  output logic      gate1_out
);
  // bench calls this first so every pin write comes from one process
  task idle;
    {cnt0_out, cnt1_out, gate0_out, gate1_out} = 4'hf;
  endtask

  // hold of 6 clocks a level is the fastest legal rate; larger values model a slow source
  task falls(input int n, input int hold);
    repeat (n) begin
      {cnt0_out, cnt1_out} <= 2'h3;
      repeat (hold) @(posedge sys_clk_in);
      {cnt0_out, cnt1_out} <= 2'h0;
      repeat (hold) @(posedge sys_clk_in);
    end
  endtask

  task set_gate(input logic g0, input logic g1);
    gate0_out <= g0;
    gate1_out <= g1;
    repeat (12) @(posedge sys_clk_in);
  endtask
endmodule

// ===== tb/test_dual_timer_counter_four_mode.sv
`timescale 1ns/10ps
module test_dual_timer_counter_four_mode;
  logic        sys_clk, rst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, ovf;
  logic        c0, c1, g0, g1;
  int          num_errors, checked;

  dtc_top u_dut (.sys_clk_in(sys_clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .count_input_zero_in(c0), .count_input_one_in(c1), .gate_input_zero_in(g0),
    .gate_input_one_in(g1), .ovf_flag_out(ovf));
  dtc_pin_model u_pins (.sys_clk_in(sys_clk), .cnt0_out(c0), .cnt1_out(c1),
    .gate0_out(g0), .gate1_out(g1));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= dtc_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // load, run for n clocks, stop: counts depend on the machine cycle rate
  task run_t(input logic [7:0] mode, input logic [31:0] a, input logic [15:0] v, input int n);
    xfer(1'b1, dtc_pkg::ADDR_MODE, {24'h0, mode});
    xfer(1'b1, a, {16'h0, v});
    xfer(1'b1, dtc_pkg::ADDR_CTRL, 32'h3);
    repeat (n) @(posedge sys_clk);
    xfer(1'b1, dtc_pkg::ADDR_CTRL, 32'h0);
  endtask

  task t_reset_map;
    for (int i = 0; i < 6; i++) rd_chk(32'(4 * i), 32'h0);
    xfer(1'b1, 32'h14, 32'hffff_ffff);
    rd_chk(32'h14, 32'h0);
  endtask

  task t_modes;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, dtc_pkg::ADDR_MODE, 32'(8'h11 * i | 8'h44));
      rd_chk(dtc_pkg::ADDR_MODE, 32'(8'h11 * i | 8'h44));
    end
  endtask

  task t_wide;
    run_t(8'h01, dtc_pkg::ADDR_COUNT0, 16'h00fe, 60);
    xfer(1'b0, dtc_pkg::ADDR_COUNT0, 32'h0);
    chk_rng(q, 32'h0107, 32'h0109);
    run_t(8'h01, dtc_pkg::ADDR_COUNT0, 16'hfffe, 30);
    chk({30'h0, ovf}, 32'h1);
    rd_chk(dtc_pkg::ADDR_STATUS, 32'h1);
    xfer(1'b1, dtc_pkg::ADDR_STATUS, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, ovf}, 32'h0);
  endtask

  task t_prescale;
    run_t(8'h00, dtc_pkg::ADDR_COUNT0, 16'h0000, 600);
    rd_chk(dtc_pkg::ADDR_COUNT0, 32'h3);
  endtask

  task t_reload;
    run_t(8'h02, dtc_pkg::ADDR_COUNT0, 16'ha0fe, 30);
    xfer(1'b0, dtc_pkg::ADDR_COUNT0, 32'h0);
    chk_rng(q, 32'ha0a2, 32'ha0a4);
    chk({31'h0, ovf[0]}, 32'h1);
    xfer(1'b1, dtc_pkg::ADDR_STATUS, 32'h3);
  endtask

  task t_split;
    xfer(1'b1, dtc_pkg::ADDR_COUNT1, 32'h1234);
    run_t(8'h33, dtc_pkg::ADDR_COUNT0, 16'hfc00, 60);
    xfer(1'b0, dtc_pkg::ADDR_COUNT0, 32'h0);
    chk_rng({24'h0, q[7:0]}, 32'h9, 32'hb);
    chk_rng({24'h0, q[15:8]}, 32'h5, 32'h7);
    chk({31'h0, ovf[1]}, 32'h1);
    rd_chk(dtc_pkg::ADDR_COUNT1, 32'h1234);
    xfer(1'b1, dtc_pkg::ADDR_STATUS, 32'h3);
    // timer 1 alone in its split code must hold even at the wrap point
    run_t(8'h31, dtc_pkg::ADDR_COUNT1, 16'hffff, 60);
    rd_chk(dtc_pkg::ADDR_COUNT1, 32'hffff);
    chk({31'h0, ovf[1]}, 32'h0);
  endtask

  task t_pins;
    xfer(1'b1, dtc_pkg::ADDR_MODE, 32'hd5);
    xfer(1'b1, dtc_pkg::ADDR_COUNT0, 32'h0);
    xfer(1'b1, dtc_pkg::ADDR_COUNT1, 32'h0);
    xfer(1'b1, dtc_pkg::ADDR_CTRL, 32'h3);
    u_pins.falls(4, 6);
    u_pins.set_gate(1'b0, 1'b0);
    u_pins.falls(3, 20);
    repeat (30) @(posedge sys_clk);
    xfer(1'b1, dtc_pkg::ADDR_CTRL, 32'h0);
    rd_chk(dtc_pkg::ADDR_COUNT0, 32'h7);
    rd_chk(dtc_pkg::ADDR_COUNT1, 32'h4);
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    {rst, hsel, hwrite, haddr, hwdata, htrans, num_errors, checked} = '0;
    u_pins.idle();
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({30'h0, ovf}, 32'h0);
    t_reset_map();
    t_modes();
    t_wide();
    t_prescale();
    t_reload();
    t_split();
    t_pins();
    end_of_test();
  end
endmodule
